// file: bridge_regs_pkg.sv
// constants for the bridge subsystem alias and general control registers
// assumes a config-space port with dword address and byte enables
package bridge_regs_pkg;
    localparam logic [7:0]  SUBSYS_ALIAS_OFS   = 8'hd0;
    localparam logic [7:0]  GEN_CTRL_OFS       = 8'hd4;
    localparam logic [7:0]  SUBSYS_VENDOR_OFS  = 8'h84;
    localparam logic [7:0]  SUBSYS_ID_OFS      = 8'h86;
    localparam logic [31:0] SUBSYS_ALIAS_RST   = 32'h00000000;
    localparam logic [31:0] GEN_CTRL_RST       = 32'h8206c000;
    localparam logic [31:0] GEN_CTRL_WMASK     = 32'hcff00000;
    localparam int          RETRY_SEL_LSB      = 30;
    localparam int          LOW_SWING_BIT      = 27;
    localparam int          PM_REV_BIT         = 26;
    localparam int          STRICT_PRIO_BIT    = 25;
    localparam int          READ_FORCE_BIT     = 24;
    localparam int          LINK_PM_DEF_BIT    = 23;
    localparam int          SLOT_RESP_LSB      = 20;
    localparam logic [2:0]  PM_REV_OLD         = 3'h2;
    localparam logic [2:0]  PM_REV_NEW         = 3'h3;
    localparam logic [2:0]  LOW_PRIO_CNT_LOOSE = 3'h1;
    localparam logic [2:0]  LOW_PRIO_CNT_STRICT = 3'h0;
    localparam logic [1:0]  LINK_PM_OFF        = 2'h0;
    localparam logic [1:0]  LINK_PM_ON         = 2'h3;
    localparam int          CLK_MHZ            = 100;
    localparam int          RETRY_T0_US        = 25;
    localparam int          RETRY_T1_MS        = 1;
    localparam int          RETRY_T2_MS        = 25;
    localparam int          RETRY_T3_MS        = 50;
    localparam int          RETRY_CYC0         = RETRY_T0_US * CLK_MHZ;
    localparam int          RETRY_CYC1         = RETRY_T1_MS * 1000 * CLK_MHZ;
    localparam int          RETRY_CYC2         = RETRY_T2_MS * 1000 * CLK_MHZ;
    localparam int          RETRY_CYC3         = RETRY_T3_MS * 1000 * CLK_MHZ;
    localparam logic [2:0]  SLOT_IGNORE        = 3'h0;
    localparam logic [2:0]  SLOT_UR_ALL        = 3'h4;
endpackage : bridge_regs_pkg

// file: retry_timer.sv
// configuration retry window timer on the secondary bus
// assumes start is a one-cycle pulse from the config forwarding logic
`timescale 1ns/1ps
module retry_timer
    import bridge_regs_pkg::*;
#(
    parameter int CYC0 = RETRY_CYC0,
    parameter int CYC1 = RETRY_CYC1,
    parameter int CYC2 = RETRY_CYC2,
    parameter int CYC3 = RETRY_CYC3
) (
    input  wire logic       clk,
    input  wire logic       sys_rst,
    input  wire logic [1:0] sel,
    input  wire logic       start,
    input  wire logic       done,
    output logic            expired
);
    // the down-counter is 32 bits wide and a window needs at least one cycle
    if (CYC0 < 1 || CYC1 < 1 || CYC2 < 1 || CYC3 < 1 || CYC3 >= (1 << 30)) begin : g_bad_counts
        $error("retry_timer: bad cycle counts");
    end

    // limit latched at start, so a select change mid-retry does not shorten it
    function automatic logic [31:0] limit_of(input logic [1:0] s);
        unique case (s)
            2'h0: limit_of = 32'(CYC0);
            2'h1: limit_of = 32'(CYC1);
            2'h2: limit_of = 32'(CYC2);
            2'h3: limit_of = 32'(CYC3);
        endcase
    endfunction : limit_of

    logic [31:0] cnt_q, cnt_d;
    logic        run_q, run_d;
    logic        exp_q, exp_d;

    always_comb begin
        cnt_d = cnt_q;
        run_d = run_q;
        exp_d = 1'b0;
        if (start) begin
            cnt_d = limit_of(sel) - 32'h1;
            run_d = 1'b1;
        end else if (done) begin
            run_d = 1'b0;
        end else if (run_q) begin
            if (cnt_q == 32'h0) begin
                run_d = 1'b0;
                exp_d = 1'b1;
            end else begin
                cnt_d = cnt_q - 32'h1;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            cnt_q <= 32'h0;
            run_q <= 1'b0;
            exp_q <= 1'b0;
        end else begin
            cnt_q <= cnt_d;
            run_q <= run_d;
            exp_q <= exp_d;
        end
    end

    assign expired = exp_q;
endmodule : retry_timer

// file: bridge_general_control_regs.sv
// subsystem alias and general control registers of the bridge config space
// assumes one-cycle config accesses, dword address, byte enables, and that
// the 84h/86h identity registers live here as the single copy of the values
//
// Functional notes
// - alias upper half shows at 86h
// - alias lower half shows at 84h
// - fundamental, global, power-on reset restore defaults
// - retry secondary config for selected time
// - timeout codes 25us,1ms,25ms,50ms; reset 10
// - bits 29:28 read zero
// - bit 27 selects half-swing, no pre-emphasis
// - bit 26 picks pm_revision_field and flag
// - strict plus count zero favours extended channel
// - strict select sets low-priority count default
// - bit 24 forces prefetchable read multiple
// - bit 23 sets link pm power-up value
// - slot limit code drives override, clock stop
// - code 100 answers unsupported except config and slot power
`timescale 1ns/1ps
module bridge_general_control_regs
    import bridge_regs_pkg::*;
#(
    parameter int RETRY_CYC0_P = RETRY_CYC0,
    parameter int RETRY_CYC1_P = RETRY_CYC1,
    parameter int RETRY_CYC2_P = RETRY_CYC2,
    parameter int RETRY_CYC3_P = RETRY_CYC3
) (
    input  wire logic        clk,
    input  wire logic        sys_rst,
    input  wire logic        pcie_fund_rst,
    input  wire logic        global_reset_in,
    input  wire logic        cfg_wr,
    input  wire logic        cfg_rd,
    input  wire logic [7:0]  cfg_addr,
    input  wire logic [3:0]  cfg_be,
    input  wire logic [31:0] cfg_wdata,
    output logic [31:0]      cfg_rdata,
    output logic             cfg_hit,
    input  wire logic        sec_cfg_start,
    input  wire logic        sec_cfg_done,
    output logic             sec_cfg_retry_expired,
    input  wire logic        slot_power_short,
    input  wire logic        txn_is_cfg_or_spl,
    input  wire logic        ext_vc_req,
    input  wire logic        vc0_req,
    input  wire logic [2:0]  low_prio_count,
    input  wire logic        up_mem_read,
    output logic [15:0]      board_product_code_alias,
    output logic [15:0]      board_maker_code_alias,
    output logic             tx_low_swing,
    output logic [2:0]       pm_revision_field,
    output logic             pm_no_soft_reset,
    output logic [2:0]       low_prio_count_default,
    output logic             ext_vc_grant,
    output logic             vc0_grant,
    output logic             upstream_read_prefetch_force,
    output logic             mem_read_as_multiple,
    output logic [1:0]       link_pm_control_field,
    output logic             overbudget_indicator_out,
    output logic             sec_clock_mask_stop,
    output logic             unsupported_request
);
    // all three reset sources restore the same state
    logic        rst_any;
    logic        glb_s1_q, glb_s2_q;
    logic        fund_s1_q, fund_s2_q;
    logic [31:0] alias_q, alias_d;
    logic [31:0] ctrl_q, ctrl_d;
    logic [1:0]  pm_link_q, pm_link_d;

    // pins from outside are synchronised; reset itself stays synchronous
    always_ff @(posedge clk) begin
        glb_s1_q  <= global_reset_in;
        glb_s2_q  <= glb_s1_q;
        fund_s1_q <= pcie_fund_rst;
        fund_s2_q <= fund_s1_q;
    end

    assign rst_any = sys_rst | glb_s2_q | fund_s2_q;

    // the timer holds the longest window in 32 bits and needs at least one cycle
    if (RETRY_CYC0_P < 1 || RETRY_CYC1_P < 1 || RETRY_CYC2_P < 1 || RETRY_CYC3_P < 1
        || RETRY_CYC3_P >= (1 << 30)) begin : g_bad_retry
        $error("bridge_general_control_regs: retry cycle counts out of range");
    end

    function automatic logic [31:0] merge_be(input logic [31:0] old_v,
                                             input logic [31:0] new_v,
                                             input logic [3:0]  be);
        logic [31:0] r;
        r = old_v;
        for (int i = 0; i < 4; i++) begin
            if (be[i]) r[i*8 +: 8] = new_v[i*8 +: 8];
        end
        return r;
    endfunction : merge_be

    logic hit_alias, hit_ctrl, hit_ids;
    assign hit_alias = cfg_addr == SUBSYS_ALIAS_OFS;
    assign hit_ctrl  = cfg_addr == GEN_CTRL_OFS;
    // 84h and 86h share the dword at 84h
    assign hit_ids   = cfg_addr == SUBSYS_VENDOR_OFS;

    always_comb begin
        alias_d   = alias_q;
        ctrl_d    = ctrl_q;
        pm_link_d = pm_link_q;
        if (cfg_wr && (hit_alias || hit_ids)) begin
            // one store, so the alias and the identity registers never diverge
            alias_d = merge_be(alias_q, cfg_wdata, cfg_be);
        end
        if (cfg_wr && hit_ctrl) begin
            // reserved bits 29:28 and the lower, out-of-scope bits stay fixed
            ctrl_d = (merge_be(ctrl_q, cfg_wdata, cfg_be) & GEN_CTRL_WMASK)
                   | (GEN_CTRL_RST & ~GEN_CTRL_WMASK);
        end
        // the link control field reloads this default every cycle, so one cycle later it
        // follows the select rather than freezing the reset value of bit 23
        pm_link_d = ctrl_q[LINK_PM_DEF_BIT] ? LINK_PM_ON : LINK_PM_OFF;
    end

    always_ff @(posedge clk) begin
        if (rst_any) begin
            alias_q    <= SUBSYS_ALIAS_RST;
            ctrl_q     <= GEN_CTRL_RST;
            pm_link_q  <= LINK_PM_OFF;
        end else begin
            alias_q    <= alias_d;
            ctrl_q     <= ctrl_d;
            pm_link_q  <= pm_link_d;
        end
    end

    // read data registered; unmapped offsets read zero and leave cfg_hit low
    logic [31:0] rdata_q, rdata_d;
    logic        hit_q, hit_d;

    always_comb begin
        rdata_d = 32'h0;
        hit_d   = 1'b0;
        if (cfg_rd) begin
            if (hit_alias || hit_ids) begin
                rdata_d = alias_q;
                hit_d   = 1'b1;
            end else if (hit_ctrl) begin
                rdata_d = ctrl_q & 32'hcfffffff;
                hit_d   = 1'b1;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (rst_any) begin
            rdata_q <= 32'h0;
            hit_q   <= 1'b0;
        end else begin
            rdata_q <= rdata_d;
            hit_q   <= hit_d;
        end
    end

    assign cfg_rdata = rdata_q;
    assign cfg_hit   = hit_q;

    retry_timer #(
        .CYC0 (RETRY_CYC0_P),
        .CYC1 (RETRY_CYC1_P),
        .CYC2 (RETRY_CYC2_P),
        .CYC3 (RETRY_CYC3_P)
    ) u_retry (
        .clk     (clk),
        .sys_rst (rst_any),
        .sel     (ctrl_q[RETRY_SEL_LSB +: 2]),
        .start   (sec_cfg_start),
        .done    (sec_cfg_done),
        .expired (sec_cfg_retry_expired)
    );

    // action bits: 0 override pin, 1 clock stop, 2 unsupported request;
    // reserved codes 101-111 fall back to ignore
    function automatic logic [2:0] slot_action(input logic [2:0] code);
        logic [2:0] act;
        act = 3'h0;
        case (code)
            SLOT_IGNORE: act = 3'h0;
            3'h1:        act = 3'h1;
            3'h2:        act = 3'h2;
            3'h3:        act = 3'h3;
            SLOT_UR_ALL: act = 3'h4;
            default:     act = 3'h0;
        endcase
        return act;
    endfunction : slot_action

    logic [2:0] slot_sel;
    logic [2:0] slot_act;
    logic       strict_ok;
    assign slot_sel  = ctrl_q[SLOT_RESP_LSB +: 3];
    assign slot_act  = slot_action(slot_sel);
    assign strict_ok = ctrl_q[STRICT_PRIO_BIT] && (low_prio_count == 3'h0);

    assign board_product_code_alias     = alias_q[31:16];
    assign board_maker_code_alias       = alias_q[15:0];
    assign tx_low_swing                 = ctrl_q[LOW_SWING_BIT];
    assign pm_revision_field            = ctrl_q[PM_REV_BIT] ? PM_REV_NEW : PM_REV_OLD;
    assign pm_no_soft_reset             = ctrl_q[PM_REV_BIT];
    assign low_prio_count_default       = ctrl_q[STRICT_PRIO_BIT] ? LOW_PRIO_CNT_STRICT
                                                                  : LOW_PRIO_CNT_LOOSE;
    assign ext_vc_grant                 = ext_vc_req;
    // without strict priority vc0 still goes when the extended channel waits
    assign vc0_grant                    = vc0_req && !(strict_ok && ext_vc_req);
    assign upstream_read_prefetch_force = ctrl_q[READ_FORCE_BIT];
    assign mem_read_as_multiple         = up_mem_read && ctrl_q[READ_FORCE_BIT];
    assign link_pm_control_field        = pm_link_q;
    assign overbudget_indicator_out     = slot_power_short && slot_act[0];
    assign sec_clock_mask_stop          = slot_power_short && slot_act[1];
    // config and slot power messages still pass, so software can lower the code
    assign unsupported_request          = slot_power_short && slot_act[2]
                                          && !txn_is_cfg_or_spl;
endmodule : bridge_general_control_regs

// file: bridge_general_control_regs_monitor.sv
// port-level checker for the bridge alias and general control registers
// assumes one clock and a synchronous active-high sys_rst
`timescale 1ns/1ps
module bridge_general_control_regs_monitor
    import bridge_regs_pkg::*;
(
    input wire logic        clk,
    input wire logic        sys_rst,
    input wire logic        cfg_wr,
    input wire logic        cfg_rd,
    input wire logic [7:0]  cfg_addr,
    input wire logic [3:0]  cfg_be,
    input wire logic [31:0] cfg_wdata,
    input wire logic [31:0] cfg_rdata,
    input wire logic        cfg_hit,
    input wire logic        sec_cfg_start,
    input wire logic        sec_cfg_retry_expired,
    input wire logic        slot_power_short,
    input wire logic        txn_is_cfg_or_spl,
    input wire logic        ext_vc_req,
    input wire logic [2:0]  low_prio_count,
    input wire logic        up_mem_read,
    input wire logic [2:0]  pm_revision_field,
    input wire logic        pm_no_soft_reset,
    input wire logic [2:0]  low_prio_count_default,
    input wire logic        ext_vc_grant,
    input wire logic        vc0_grant,
    input wire logic        upstream_read_prefetch_force,
    input wire logic        mem_read_as_multiple,
    input wire logic        overbudget_indicator_out,
    input wire logic        sec_clock_mask_stop,
    input wire logic        unsupported_request
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (sys_rst);
    sequence d4_write;
        cfg_wr && cfg_addr == GEN_CTRL_OFS && cfg_be[3];
    endsequence
    // the shortest window in use is longer than this
    sequence retry_quiet;
        !sec_cfg_retry_expired [*3];
    endsequence
    chk_pm_pair: assert property (
        pm_revision_field == (pm_no_soft_reset ? PM_REV_NEW : PM_REV_OLD))
        else $error("pm_revision_field and flag disagree");
    chk_prio_default: assert property (
        d4_write |=> low_prio_count_default ==
            ($past(cfg_wdata[25]) ? LOW_PRIO_CNT_STRICT : LOW_PRIO_CNT_LOOSE))
        else $error("low priority count default wrong");
    chk_vc_strict: assert property (
        ext_vc_req && low_prio_count == 3'h0 && low_prio_count_default == LOW_PRIO_CNT_STRICT
        |-> ext_vc_grant && !vc0_grant)
        else $error("vc0 granted under strict priority");
    chk_read_force: assert property (
        mem_read_as_multiple == (up_mem_read && upstream_read_prefetch_force))
        else $error("read multiple forcing wrong");
    chk_slot_idle: assert property (
        !slot_power_short |-> !(overbudget_indicator_out || sec_clock_mask_stop
                                || unsupported_request))
        else $error("slot response without shortfall");
    chk_ur_exempt: assert property (
        txn_is_cfg_or_spl |-> !unsupported_request)
        else $error("config or slot message refused");
    chk_rsvd_zero: assert property (
        cfg_rd && cfg_addr == GEN_CTRL_OFS |=> cfg_hit && cfg_rdata[29:28] == 2'h0)
        else $error("reserved bits read nonzero");
    chk_retry_quiet: assert property (
        sec_cfg_start |=> retry_quiet)
        else $error("retry window ended at once");
endmodule : bridge_general_control_regs_monitor

bind bridge_general_control_regs bridge_general_control_regs_monitor mon (
    .clk(clk), .sys_rst(sys_rst), .cfg_wr(cfg_wr), .cfg_rd(cfg_rd), .cfg_addr(cfg_addr),
    .cfg_be(cfg_be), .cfg_wdata(cfg_wdata), .cfg_rdata(cfg_rdata), .cfg_hit(cfg_hit),
    .sec_cfg_start(sec_cfg_start), .sec_cfg_retry_expired(sec_cfg_retry_expired),
    .slot_power_short(slot_power_short), .txn_is_cfg_or_spl(txn_is_cfg_or_spl),
    .ext_vc_req(ext_vc_req), .low_prio_count(low_prio_count), .up_mem_read(up_mem_read),
    .pm_revision_field(pm_revision_field), .pm_no_soft_reset(pm_no_soft_reset),
    .low_prio_count_default(low_prio_count_default), .ext_vc_grant(ext_vc_grant),
    .vc0_grant(vc0_grant), .upstream_read_prefetch_force(upstream_read_prefetch_force),
    .mem_read_as_multiple(mem_read_as_multiple),
    .overbudget_indicator_out(overbudget_indicator_out),
    .sec_clock_mask_stop(sec_clock_mask_stop), .unsupported_request(unsupported_request)
);

// file: test_bridge_general_control_regs.sv
// self-checking bench for the bridge alias and general control registers
// assumes one-cycle config strobes; retry counts shortened to 5,10,20,40
`timescale 1ns/1ps
`define CHK(nm, e, g) begin n_checks++; if ((g) !== (e)) begin mismatches++; \
    $display("BAD %s exp %h got %h", nm, e, g); end end
module test_bridge_general_control_regs
    import bridge_regs_pkg::*;
;
    localparam int CYC [4] = '{5, 10, 20, 40};
    logic        clk, sys_rst, pcie_fund_rst, global_reset_in, cfg_wr, cfg_rd, cfg_hit;
    logic        sec_cfg_start, sec_cfg_done, slot_power_short, txn_is_cfg_or_spl;
    logic        ext_vc_req, vc0_req, up_mem_read, sec_cfg_retry_expired, tx_low_swing;
    logic        pm_no_soft_reset, ext_vc_grant, vc0_grant, upstream_read_prefetch_force;
    logic        mem_read_as_multiple, overbudget_indicator_out, sec_clock_mask_stop;
    logic        unsupported_request;
    logic [7:0]  cfg_addr;
    logic [3:0]  cfg_be;
    logic [31:0] cfg_wdata, cfg_rdata;
    logic [2:0]  low_prio_count, pm_revision_field, low_prio_count_default;
    logic [15:0] board_product_code_alias, board_maker_code_alias;
    logic [1:0]  link_pm_control_field;
    int          mismatches = 0;
    int          n_checks = 0;
    int          n;
    bridge_general_control_regs #(.RETRY_CYC0_P(CYC[0]), .RETRY_CYC1_P(CYC[1]),
        .RETRY_CYC2_P(CYC[2]), .RETRY_CYC3_P(CYC[3])) dut (
        .clk(clk), .sys_rst(sys_rst), .pcie_fund_rst(pcie_fund_rst),
        .global_reset_in(global_reset_in), .cfg_wr(cfg_wr), .cfg_rd(cfg_rd),
        .cfg_addr(cfg_addr), .cfg_be(cfg_be), .cfg_wdata(cfg_wdata), .cfg_rdata(cfg_rdata),
        .cfg_hit(cfg_hit), .sec_cfg_start(sec_cfg_start), .sec_cfg_done(sec_cfg_done),
        .sec_cfg_retry_expired(sec_cfg_retry_expired), .slot_power_short(slot_power_short),
        .txn_is_cfg_or_spl(txn_is_cfg_or_spl), .ext_vc_req(ext_vc_req), .vc0_req(vc0_req),
        .low_prio_count(low_prio_count), .up_mem_read(up_mem_read),
        .board_product_code_alias(board_product_code_alias),
        .board_maker_code_alias(board_maker_code_alias), .tx_low_swing(tx_low_swing),
        .pm_revision_field(pm_revision_field), .pm_no_soft_reset(pm_no_soft_reset),
        .low_prio_count_default(low_prio_count_default), .ext_vc_grant(ext_vc_grant),
        .vc0_grant(vc0_grant), .upstream_read_prefetch_force(upstream_read_prefetch_force),
        .mem_read_as_multiple(mem_read_as_multiple),
        .link_pm_control_field(link_pm_control_field),
        .overbudget_indicator_out(overbudget_indicator_out),
        .sec_clock_mask_stop(sec_clock_mask_stop), .unsupported_request(unsupported_request)
    );
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    task automatic print_verdict();
        $display("checks %0d mismatches %0d", n_checks, mismatches);
        if (mismatches == 0 && n_checks > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask : print_verdict
    task automatic wr(input logic [7:0] a, input logic [3:0] be, input logic [31:0] d);
        @(posedge clk);
        cfg_wr    <= 1'b1;
        cfg_addr  <= a;
        cfg_be    <= be;
        cfg_wdata <= d;
        @(posedge clk);
        cfg_wr    <= 1'b0;
    endtask : wr
    task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic h);
        @(posedge clk);
        cfg_rd   <= 1'b1;
        cfg_addr <= a;
        @(posedge clk);
        cfg_rd   <= 1'b0;
        #1;
        `CHK("rdata", e, cfg_rdata)
        `CHK("hit", h, cfg_hit)
    endtask : rd
    initial begin
        {pcie_fund_rst, global_reset_in, cfg_wr, cfg_rd, sec_cfg_start, sec_cfg_done} = '0;
        {slot_power_short, txn_is_cfg_or_spl, ext_vc_req, vc0_req, up_mem_read} = '0;
        {cfg_addr, cfg_be, cfg_wdata, low_prio_count} = '0;
        sys_rst = 1'b1;
        repeat (10) @(posedge clk);
        sys_rst <= 1'b0;
        rd(SUBSYS_ALIAS_OFS, SUBSYS_ALIAS_RST, 1'b1);
        rd(GEN_CTRL_OFS, GEN_CTRL_RST, 1'b1);
        rd(8'h10, 32'h0, 1'b0);
        `CHK("pmrev", PM_REV_OLD, pm_revision_field)
        `CHK("prio", LOW_PRIO_CNT_STRICT, low_prio_count_default)
        `CHK("linkpm", LINK_PM_OFF, link_pm_control_field)
        $display("reset test done");
        wr(SUBSYS_ALIAS_OFS, 4'hf, 32'h1234abcd);
        rd(SUBSYS_VENDOR_OFS, 32'h1234abcd, 1'b1);
        `CHK("product", 16'h1234, board_product_code_alias)
        `CHK("maker", 16'habcd, board_maker_code_alias)
        wr(SUBSYS_VENDOR_OFS, 4'h3, 32'hffff5678);
        rd(SUBSYS_ALIAS_OFS, 32'h12345678, 1'b1);
        $display("alias test done");
        wr(GEN_CTRL_OFS, 4'hf, 32'hffffffff);
        rd(GEN_CTRL_OFS, 32'hcff6c000, 1'b1);
        `CHK("swing", 1'b1, tx_low_swing)
        `CHK("nosoft", 1'b1, pm_no_soft_reset)
        `CHK("pmrev", PM_REV_NEW, pm_revision_field)
        `CHK("force", 1'b1, upstream_read_prefetch_force)
        `CHK("linkpm", LINK_PM_ON, link_pm_control_field)
        @(posedge clk);
        {up_mem_read, ext_vc_req, vc0_req} <= 3'h7;
        @(posedge clk);
        #1;
        `CHK("mrm", 1'b1, mem_read_as_multiple)
        `CHK("vc0", 1'b0, vc0_grant)
        `CHK("extvc", 1'b1, ext_vc_grant)
        @(posedge clk);
        low_prio_count <= 3'h1;
        @(posedge clk);
        #1;
        `CHK("vc0", 1'b1, vc0_grant)
        @(posedge clk);
        low_prio_count <= 3'h0;
        wr(GEN_CTRL_OFS, 4'hf, 32'h0);
        rd(GEN_CTRL_OFS, 32'h0006c000, 1'b1);
        `CHK("swing", 1'b0, tx_low_swing)
        `CHK("linkpm", LINK_PM_OFF, link_pm_control_field)
        `CHK("prio", LOW_PRIO_CNT_LOOSE, low_prio_count_default)
        `CHK("mrm", 1'b0, mem_read_as_multiple)
        `CHK("vc0", 1'b1, vc0_grant)
        $display("control test done");
        slot_power_short <= 1'b1;
        for (int c = 0; c < 9; c++) begin
            wr(GEN_CTRL_OFS, 4'hf, {9'h0, ((c == 8) ? SLOT_UR_ALL : c[2:0]), 20'h0});
            txn_is_cfg_or_spl <= (c == 8);
            @(posedge clk);
            #1;
            `CHK("ovr", c == 1 || c == 3, overbudget_indicator_out)
            `CHK("stop", c == 2 || c == 3, sec_clock_mask_stop)
            `CHK("ur", c == 4, unsupported_request)
        end
        $display("slot test done");
        for (int s = 0; s < 5; s++) begin
            wr(GEN_CTRL_OFS, 4'hf, {s[1:0], 30'h0006c000});
            sec_cfg_start <= 1'b1;
            @(posedge clk);
            sec_cfg_start <= 1'b0;
            sec_cfg_done  <= (s == 4);
            n = 0;
            while (sec_cfg_retry_expired !== 1'b1 && n < 60) begin
                @(posedge clk);
                sec_cfg_done <= 1'b0;
                #1;
                n++;
            end
            if (s < 4) `CHK("retry", CYC[s], n)
            else `CHK("cancel", 60, n)
        end
        $display("retry test done");
        for (int r = 0; r < 2; r++) begin
            wr(SUBSYS_ALIAS_OFS, 4'hf, 32'h5a5a0f0f);
            pcie_fund_rst   <= (r == 0);
            global_reset_in <= (r == 1);
            repeat (4) @(posedge clk);
            pcie_fund_rst   <= 1'b0;
            global_reset_in <= 1'b0;
            repeat (4) @(posedge clk);
            rd(SUBSYS_ALIAS_OFS, SUBSYS_ALIAS_RST, 1'b1);
            rd(GEN_CTRL_OFS, GEN_CTRL_RST, 1'b1);
        end
        $display("external reset test done");
        print_verdict();
    end
    // whole run needs well under 2000 cycles
    initial begin
        #50000;
        mismatches++;
        print_verdict();
    end
endmodule : test_bridge_general_control_regs
